/* common/ips_pkg.sv */
// Shared constants and types of the inverter protection supervisor.
package ips_pkg;
   // System clock period in nanoseconds (20 MHz).
   localparam int CLOCK_PERIOD_NS = 50;
   // Switch sampling period in nanoseconds (1 ms).
   localparam int SWITCH_PERIOD_NS = 1_000_000;
   // Protection check period in nanoseconds (187.5 us).
   localparam int GUARD_PERIOD_NS = 187_500;
   // Clock cycles per switch sample; the top module exposes this as a parameter.
   localparam int SWITCH_CYCLES = SWITCH_PERIOD_NS / CLOCK_PERIOD_NS;
   // Clock cycles per protection check.
   localparam int GUARD_CYCLES = GUARD_PERIOD_NS / CLOCK_PERIOD_NS;
   // Full converter code.
   localparam int CODE_MAX = 32'h0000_03FF;
   // Bus voltage at full code, and the trip limits, in millivolts.
   localparam int BUS_FULL_MV = 25000;
   localparam int BUS_OVER_MV = 24000;
   localparam int BUS_UNDER_MV = 3000;
   // Phase current at each end of the code range, and the trip limit, in milliamperes.
   localparam int PHASE_FULL_MA = 83300;
   localparam int PHASE_TRIP_MA = 15000;
   // Width of a converter code and of the duty setting.
   localparam int CODE_W = 10;
   // Duty value after reset and whenever the stage is stopped.
   localparam logic [9:0] DUTY_RESET = 10'h000;

   // Reported error kinds.
   typedef enum logic [1:0] {
      ERR_NONE  = 2'b00,
      ERR_OVERI = 2'b01,
      ERR_OVERV = 2'b10,
      ERR_UNDERV = 2'b11
   } ips_err_type;

   // Drive sequence states.
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_OPEN   = 2'b01,
      ST_CLOSED = 2'b10,
      ST_FAULT  = 2'b11
   } ips_state_type;
endpackage

/* common/ips_tick_if.sv */
// Tick enables passed from the periodic tick timer to the supervisor.
`timescale 1ns/1ns
interface ips_tick_if;
   logic tickSwitch;   // One-cycle pulse every switch sampling period.
   logic tickGuard;    // One-cycle pulse every protection check period.
   modport timer (output tickSwitch, output tickGuard);
   modport user  (input tickSwitch, input tickGuard);
endinterface

/* rtl/ips_supervisor.sv */
// Inverter protection supervisor: start/stop, scaling, drive sequence, PI loop, duty and trips.
// Contract
// - Sample the switch once per 1 ms tick.
// - Sampled low switch requests motor running.
// - Sampled switch going high requests motor stop.
// - Bus code 0000H..03FFH maps 0..25 V.
// - Phase codes 0000H..03FFH map -83.3..+83.3 A.
// - Abnormal bus voltage stops PWM drive.
// - Hardware over-current input tri-states PWM pins directly.
// - Every 187.5 us, current above 15 A trips.
// - Every 187.5 us, bus above 24 V trips.
// - Bus below 3 V trips.
// - Three distinct error types, each trips.
// - Open loop first, vector control after fixed time.
// - PI speed regulation in closed loop.
// - Modulation factor written to PWM duty setting.
`timescale 1ns/1ns
module ips_supervisor #(
   parameter int SWITCH_CYCLES = ips_pkg::SWITCH_CYCLES,  // Cycles per 1 ms switch sample.
   parameter int OPEN_TICKS    = 500,                     // Switch ticks spent in open loop.
   parameter int OPEN_DUTY     = 128,                     // Duty used in open loop.
   parameter int KP            = 4,                       // PI proportional gain.
   parameter int KI            = 1,                       // PI integral gain.
   parameter int PI_SHIFT      = 4                        // PI output scaling shift.
) (
   input  wire logic              clock,                  // System clock, 20 MHz.
   input  wire logic              rst,                    // Synchronous reset, active high.
   input  wire logic              switchSenseInput,       // Start/stop switch pin, low means pressed.
   input  wire logic              hwOvercurrentStopInput, // Hardware over-current pin, active high.
   input  wire logic [9:0]        busVoltageChannel,      // Bus voltage converter code.
   input  wire logic [9:0]        uCurrentChannel,        // U phase current converter code.
   input  wire logic [9:0]        vCurrentChannel,        // V phase current converter code.
   input  wire logic [9:0]        wCurrentChannel,        // W phase current converter code.
   input  wire logic signed [15:0] speedRef,              // Requested speed from the control side.
   input  wire logic signed [15:0] speedEst,              // Estimated speed from the sensorless estimator.
   output logic                   runRequest,             // Level: switch asks the motor to run.
   output logic                   closedLoop,             // Level: sensorless vector control active.
   output logic [1:0]             errorType,              // Latched error kind.
   output logic [9:0]             pwmDuty,                // PWM duty setting.
   output logic [2:0]             pwmPinOut,              // PWM pin levels U, V, W.
   output logic [2:0]             pwmPinOe_n              // PWM pin drive enables, low drives, high floats.
);
   // Refuse settings the 10-bit duty or counters cannot serve.
   initial begin
      if (OPEN_TICKS < 1 || OPEN_TICKS > 65535 || OPEN_DUTY < 0 || OPEN_DUTY > ips_pkg::CODE_MAX) begin
         $error("ips_supervisor: open loop setting out of range");
      end
   end

   ips_tick_if ticks ();  // Tick enables from the timer.

   // Periodic tick timer.
   ips_tick_timer #(
      .SWITCH_CYCLES (SWITCH_CYCLES),
      .GUARD_CYCLES  (ips_pkg::GUARD_CYCLES)
   ) u_timer (
      .clock (clock),
      .rst   (rst),
      .ticks (ticks.timer)
   );

   // Bus millivolts from a code, linear with 0 V at zero and 25 V at full code.
   function automatic int busMillivolts(input logic [9:0] code);
      busMillivolts = (int'(code) * ips_pkg::BUS_FULL_MV) / ips_pkg::CODE_MAX;
   endfunction

   // Phase milliamperes from a code, linear over -83.3 A to +83.3 A.
   function automatic int phaseMilliamps(input logic [9:0] code);
      phaseMilliamps = (int'(code) * 2 * ips_pkg::PHASE_FULL_MA) / ips_pkg::CODE_MAX
                       - ips_pkg::PHASE_FULL_MA;
   endfunction

   // True when a phase current magnitude is over the trip limit.
   function automatic logic phaseOver(input logic [9:0] code);
      int ma;
      ma = phaseMilliamps(code);
      phaseOver = (ma > ips_pkg::PHASE_TRIP_MA) || (ma < -ips_pkg::PHASE_TRIP_MA);
   endfunction

   // Pin synchronisers: two flops each before the sequencer reads the pins; the pin enables use the raw over-current pin.
   logic [1:0] switchSync;        // Switch pin synchroniser.
   logic [1:0] hwOcSync;          // Over-current pin synchroniser.
   always_ff @(posedge clock) begin
      if (rst) begin
         switchSync <= 2'b11;
         hwOcSync   <= 2'b00;
      end else begin
         switchSync <= {switchSync[0], switchSenseInput};
         hwOcSync   <= {hwOcSync[0], hwOvercurrentStopInput};
      end
   end

   // Checks on the current codes; trips are taken only on guard ticks.
   logic overCurrent;             // Any phase current beyond the limit.
   logic overVoltage;             // Bus voltage beyond the upper limit.
   logic underVoltage;            // Bus voltage below the lower limit.
   always_comb begin
      overCurrent  = phaseOver(uCurrentChannel) || phaseOver(vCurrentChannel) || phaseOver(wCurrentChannel);
      overVoltage  = busMillivolts(busVoltageChannel) > ips_pkg::BUS_OVER_MV;
      underVoltage = busMillivolts(busVoltageChannel) < ips_pkg::BUS_UNDER_MV;
   end

   // Sequencer state.
   ips_pkg::ips_state_type state;        // Drive sequence state.
   ips_pkg::ips_state_type next_state;   // Next drive sequence state.
   ips_pkg::ips_err_type   errLatch;     // Latched error kind.
   ips_pkg::ips_err_type   next_errLatch;// Next error kind.
   logic        switchLevel;             // Switch level seen at the last tick.
   logic        next_switchLevel;        // Next sampled switch level.
   logic        rearmed;                 // Switch has been high since the last fault.
   logic        next_rearmed;            // Next rearm flag.
   logic [15:0] openCount;               // Switch ticks spent in open loop.
   logic [15:0] next_openCount;          // Next open loop count.

   // Computes the sequence: switch sampling, start/stop, open to closed loop, trips.
   always_comb begin
      next_state       = state;
      next_errLatch    = errLatch;
      next_switchLevel = switchLevel;
      next_rearmed     = rearmed;
      next_openCount   = openCount;
      // Switch is looked at only on the periodic tick.
      if (ticks.tickSwitch) begin
         next_switchLevel = switchSync[1];
         if (switchSync[1]) begin
            next_rearmed = 1'b1;
         end
      end
      unique case (state)
         ips_pkg::ST_IDLE: begin
            // A low sample starts the drive in open loop.
            if (ticks.tickSwitch && !switchSync[1]) begin
               next_state     = ips_pkg::ST_OPEN;
               next_openCount = 16'h0000;
            end
         end
         ips_pkg::ST_OPEN: begin
            // Open loop lasts a fixed count of ticks.
            if (ticks.tickSwitch) begin
               next_openCount = openCount + 16'h0001;
               if (openCount == 16'(OPEN_TICKS - 1)) begin
                  next_state = ips_pkg::ST_CLOSED;
               end
            end
         end
         ips_pkg::ST_CLOSED: begin
            // Closed loop holds until a stop or a trip.
         end
         ips_pkg::ST_FAULT: begin
            // A fresh low sample after a high one clears the fault and restarts.
            if (ticks.tickSwitch && !switchSync[1] && rearmed) begin
               next_state     = ips_pkg::ST_OPEN;
               next_errLatch  = ips_pkg::ERR_NONE;
               next_openCount = 16'h0000;
            end
         end
      endcase
      // A high sample while driving stops the motor.
      if ((state == ips_pkg::ST_OPEN || state == ips_pkg::ST_CLOSED) && ticks.tickSwitch && switchSync[1]) begin
         next_state = ips_pkg::ST_IDLE;
      end
      // Hardware over-current latches a fault at any time; the pins float already.
      if (hwOcSync[1]) begin
         next_state    = ips_pkg::ST_FAULT;
         next_errLatch = ips_pkg::ERR_OVERI;
         next_rearmed  = 1'b0;
      end else if (ticks.tickGuard && state != ips_pkg::ST_FAULT &&
                   (overCurrent || overVoltage || underVoltage)) begin
         // Periodic checks trip an emergency stop; current wins, then over- then under-voltage.
         next_state   = ips_pkg::ST_FAULT;
         next_rearmed = 1'b0;
         if (overCurrent) begin
            next_errLatch = ips_pkg::ERR_OVERI;
         end else if (overVoltage) begin
            next_errLatch = ips_pkg::ERR_OVERV;
         end else begin
            next_errLatch = ips_pkg::ERR_UNDERV;
         end
      end
   end

   // Registers the sequence state.
   always_ff @(posedge clock) begin
      if (rst) begin
         state       <= ips_pkg::ST_IDLE;
         errLatch    <= ips_pkg::ERR_NONE;
         switchLevel <= 1'b1;
         rearmed     <= 1'b1;
         openCount   <= 16'h0000;
      end else begin
         state       <= next_state;
         errLatch    <= next_errLatch;
         switchLevel <= next_switchLevel;
         rearmed     <= next_rearmed;
         openCount   <= next_openCount;
      end
   end

   // Speed loop and duty setting, updated on each guard tick in closed loop.
   logic signed [31:0] integ;        // PI integrator.
   logic signed [31:0] next_integ;   // Next integrator value.
   logic [9:0]         next_pwmDuty; // Next duty setting.
   logic signed [31:0] speedErr;     // Speed error.
   logic signed [31:0] piOut;        // PI output before clamping.
   always_comb begin
      next_integ   = integ;
      next_pwmDuty = pwmDuty;
      speedErr     = 32'(speedRef) - 32'(speedEst);
      piOut        = (speedErr * KP + integ) >>> PI_SHIFT;
      if (state == ips_pkg::ST_CLOSED) begin
         if (ticks.tickGuard) begin
            // The integrator stops growing once the duty is saturated.
            if (!((piOut > ips_pkg::CODE_MAX && speedErr > 0) || (piOut < 0 && speedErr < 0))) begin
               next_integ = integ + speedErr * KI;
            end
            if (piOut > ips_pkg::CODE_MAX) begin
               next_pwmDuty = 10'(ips_pkg::CODE_MAX);
            end else if (piOut < 0) begin
               next_pwmDuty = ips_pkg::DUTY_RESET;
            end else begin
               next_pwmDuty = piOut[9:0];
            end
         end
      end else if (state == ips_pkg::ST_OPEN) begin
         // Open loop uses a fixed duty; the integrator starts from that level.
         next_integ   = 32'(OPEN_DUTY) <<< PI_SHIFT;
         next_pwmDuty = 10'(OPEN_DUTY);
      end else begin
         next_integ   = 32'h0000_0000;
         next_pwmDuty = ips_pkg::DUTY_RESET;
      end
   end

   // Registers the speed loop.
   always_ff @(posedge clock) begin
      if (rst) begin
         integ   <= 32'h0000_0000;
         pwmDuty <= ips_pkg::DUTY_RESET;
      end else begin
         integ   <= next_integ;
         pwmDuty <= next_pwmDuty;
      end
   end

   // Triangle carrier for the pulse width comparison.
   logic [9:0] carrier;        // Carrier count.
   logic       carrierDown;    // Carrier is counting down.
   logic [9:0] next_carrier;   // Next carrier count.
   logic       next_carrierDown; // Next carrier direction.
   logic [2:0] next_pwmPinOut; // Next pin levels.
   always_comb begin
      next_carrierDown = carrierDown;
      if (!carrierDown && carrier == 10'h3FE) begin
         next_carrierDown = 1'b1;
      end else if (carrierDown && carrier == 10'h001) begin
         next_carrierDown = 1'b0;
      end
      next_carrier   = next_carrierDown ? carrier - 10'h001 : carrier + 10'h001;
      next_pwmPinOut = {3{carrier < pwmDuty}};
   end

   // Registers the carrier and the pin levels.
   always_ff @(posedge clock) begin
      if (rst) begin
         carrier     <= 10'h000;
         carrierDown <= 1'b0;
         pwmPinOut   <= 3'b000;
      end else begin
         carrier     <= next_carrier;
         carrierDown <= next_carrierDown;
         pwmPinOut   <= next_pwmPinOut;
      end
   end

   // The raw over-current pin floats the outputs with no clocked step in between.
   always_comb begin
      pwmPinOe_n = {3{hwOvercurrentStopInput ||
                      !(state == ips_pkg::ST_OPEN || state == ips_pkg::ST_CLOSED)}};
   end

   assign runRequest = !switchLevel;
   assign closedLoop = (state == ips_pkg::ST_CLOSED);
   assign errorType  = errLatch;
endmodule

/* rtl/ips_tick_timer.sv */
// Periodic tick timer making the switch and protection enables.
`timescale 1ns/1ns
module ips_tick_timer #(
   parameter int SWITCH_CYCLES = ips_pkg::SWITCH_CYCLES,  // Cycles per switch tick.
   parameter int GUARD_CYCLES  = ips_pkg::GUARD_CYCLES    // Cycles per guard tick.
) (
   input  wire logic clock,        // System clock.
   input  wire logic rst,          // Synchronous reset, active high.
   ips_tick_if.timer ticks         // Tick enables out.
);
   // Refuse periods the 16-bit counters cannot hold.
   initial begin
      if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > 65536 || GUARD_CYCLES < 1 || GUARD_CYCLES > 65536) begin
         $error("ips_tick_timer: tick period out of range");
      end
   end

   logic [15:0] switchCount;       // Cycles left to the next switch tick.
   logic [15:0] guardCount;        // Cycles left to the next guard tick.
   logic [15:0] next_switchCount;  // Next switch counter value.
   logic [15:0] next_guardCount;   // Next guard counter value.

   // Each counter runs down and reloads; the tick fires at one.
   always_comb begin
      next_switchCount = (switchCount == 16'h0000) ? 16'(SWITCH_CYCLES - 1) : switchCount - 16'h0001;
      next_guardCount  = (guardCount == 16'h0000) ? 16'(GUARD_CYCLES - 1) : guardCount - 16'h0001;
   end

   // Registers the counters.
   always_ff @(posedge clock) begin
      if (rst) begin
         switchCount <= 16'h0000;
         guardCount  <= 16'h0000;
      end else begin
         switchCount <= next_switchCount;
         guardCount  <= next_guardCount;
      end
   end

   // Ticks are held off during reset so the first one comes a full period after release.
   assign ticks.tickSwitch = (switchCount == 16'h0001) || (SWITCH_CYCLES == 1 && !rst);
   assign ticks.tickGuard  = (guardCount == 16'h0001) || (GUARD_CYCLES == 1 && !rst);
endmodule

/* tb/ips_power_stage.sv */
// Behavioural power stage giving converter codes and the trip pin.
`timescale 1ns/1ns
module ips_power_stage (
   input  wire logic [2:0]  faultCode, // 0 healthy, 1 U high, 2 W low, 3 bus high, 4 bus low.
   input  wire logic        hwTrip,    // Comparator trip request.
   input  wire logic [15:0] noise,     // Spread of healthy readings.
   output logic      [9:0]  busCode,   // Bus code.
   output logic      [9:0]  uCode,     // U code.
   output logic      [9:0]  vCode,     // V code.
   output logic      [9:0]  wCode,     // W code.
   output logic             hwPin      // Trip pin.
);
   // Healthy readings wander inside the legal bands; faults sit on the first bad code.
   always_comb begin
      busCode = 10'h07B + 10'(noise % 16'h035C);
      uCode = 10'h1A4 + 10'(noise[15:8] % 8'hB8);
      vCode = 10'h1A4 + 10'(noise[7:0] % 8'hB8);
      wCode = 10'h1A4 + 10'(noise[11:4] % 8'hB8);
      hwPin = hwTrip;
      case (faultCode)
         3'h1: uCode = 10'h25C;
         3'h2: wCode = 10'h1A3;
         3'h3: busCode = 10'h3D7;
         3'h4: busCode = 10'h07A;
         default: ;
      endcase
   end
endmodule

/* tb/ips_supervisor_monitor.sv */
// Concurrent checks on the supervisor's ports.
`timescale 1ns/1ns
module ips_supervisor_monitor #(
   parameter int SWITCH_CYCLES = 40  // Cycles per switch sample.
) (
   input wire logic       clock,                  // System clock.
   input wire logic       rst,                    // Synchronous reset.
   input wire logic       hwOvercurrentStopInput, // Raw trip pin.
   input wire logic [9:0] busVoltageChannel,      // Bus code.
   input wire logic [9:0] uCurrentChannel,        // U code.
   input wire logic [9:0] vCurrentChannel,        // V code.
   input wire logic [9:0] wCurrentChannel,        // W code.
   input wire logic       runRequest,             // Run level.
   input wire logic       closedLoop,             // Closed loop level.
   input wire logic [1:0] errorType,              // Error kind.
   input wire logic [9:0] pwmDuty,                // Duty setting.
   input wire logic [2:0] pwmPinOe_n              // Pin enables.
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   int   runAge;       // Cycles since the run level last moved.
   int   next_runAge;  // Next value of runAge.
   logic lastRun;      // Run level one cycle back.
   logic next_lastRun; // Next value of lastRun.
   // Ages the run level so moves between samples show up.
   always_comb begin
      next_runAge = (rst || runRequest != lastRun) ? 0 : runAge + 1;
      next_lastRun = rst ? 1'b0 : runRequest;
   end
   // Registers the age counter.
   always_ff @(posedge clock) begin
      runAge <= next_runAge;
      lastRun <= next_lastRun;
   end
   // A code outside the 420..603 band is beyond 15 A either way.
   function automatic logic phaseBad(logic [9:0] c);
      return c >= 10'h25C || c <= 10'h1A3;
   endfunction
   // First cycle of a newly latched error.
   sequence fresh_trip;
      (errorType != 2'b00) && ($past(errorType) == 2'b00);
   endsequence
   hw_float_a: assert property (hwOvercurrentStopInput |-> pwmPinOe_n == 3'b111)
      else $error("pins driven while trip pin high");
   drive_run_a: assert property (pwmPinOe_n != 3'b111 |-> runRequest && errorType == 2'b00)
      else $error("pins driven without run");
   run_spacing_a: assert property (runRequest != lastRun |-> runAge >= SWITCH_CYCLES - 1)
      else $error("run level moved between samples");
   trip_float_a: assert property (fresh_trip |-> pwmPinOe_n == 3'b111)
      else $error("pins driven after trip");
   trip_duty_a: assert property (fresh_trip |=> (pwmDuty == 10'h000) [*2])
      else $error("duty not cleared after trip");
   closed_run_a: assert property (closedLoop |-> runRequest && errorType == 2'b00)
      else $error("closed loop without run");
   over_volt_a: assert property (fresh_trip ##0 errorType == 2'b10 |-> $past(busVoltageChannel) >= 10'h3D7)
      else $error("over-voltage at legal bus");
   under_volt_a: assert property (fresh_trip ##0 errorType == 2'b11 |-> $past(busVoltageChannel) <= 10'h07A)
      else $error("under-voltage at legal bus");
   over_cur_a: assert property (fresh_trip ##0 errorType == 2'b01 |->
      phaseBad($past(uCurrentChannel)) || phaseBad($past(vCurrentChannel)) || phaseBad($past(wCurrentChannel)) ||
      $past(hwOvercurrentStopInput, 2) || $past(hwOvercurrentStopInput, 3))
      else $error("over-current at legal current");
   fault_hold_a: assert property (errorType != $past(errorType) && $past(errorType) != 2'b00 |->
      errorType == 2'b01 || (errorType == 2'b00 && runRequest && !$past(runRequest)))
      else $error("error kind left without restart");
endmodule

/* tb/ips_supervisor_tb.sv */
// Self-checking bench of the inverter protection supervisor.
`timescale 1ns/1ns
module ips_supervisor_tb;
   localparam int SW = 40;                      // Shortened switch period.
   localparam int GD = ips_pkg::GUARD_CYCLES;   // Guard cadence.
   logic               clock = 1'b0;            // System clock.
   logic               rst = 1'b1;              // Reset.
   logic               sw = 1'b1;               // Switch pin.
   logic               hwTrip = 1'b0;           // Trip request.
   logic        [2:0]  fault = 3'h0;            // Stage fault kind.
   logic        [31:0] seed = 32'h0000_D10B;    // Random state.
   logic signed [15:0] est = 16'sh0000;         // Speed estimate.
   logic        [9:0]  bus, uC, vC, wC, duty;   // Codes and duty.
   logic               hwPin, runReq, closed;   // Pin and levels.
   logic               prevRun = 1'b0;          // Run level last cycle.
   logic        [1:0]  err, prevErr = 2'b00;    // Error kind now and last cycle.
   logic        [2:0]  pins, oe_n;              // Pin levels and enables.
   logic        [1:0]  errQ[$];                 // Expected error kinds.
   logic               runQ[$];                 // Expected run levels.
   logic        [1:0]  expErr[5] = '{2'b01, 2'b01, 2'b10, 2'b11, 2'b01}; // Kind per fault.
   int                 error_cnt = 0;           // Mismatches.
   int                 comparisons = 0;         // Comparisons.
   int                 hiCnt = 0;               // Cycles with all pins high in one carrier period.
   always #25 clock = ~clock;
   // Xorshift step.
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   // New random readings and estimate every cycle.
   always @(negedge clock) begin
      seed <= xs(seed);
      est <= {{8{seed[23]}}, seed[23:16]};
   end
   ips_power_stage stage (.faultCode(fault), .hwTrip(hwTrip), .noise(seed[15:0]), .busCode(bus),
      .uCode(uC), .vCode(vC), .wCode(wC), .hwPin(hwPin));
   ips_supervisor #(.SWITCH_CYCLES(SW), .OPEN_TICKS(2)) uut (.clock(clock), .rst(rst),
      .switchSenseInput(sw), .hwOvercurrentStopInput(hwPin), .busVoltageChannel(bus),
      .uCurrentChannel(uC), .vCurrentChannel(vC), .wCurrentChannel(wC),
      .speedRef(est + 16'sh0010), .speedEst(est), .runRequest(runReq), .closedLoop(closed),
      .errorType(err), .pwmDuty(duty), .pwmPinOut(pins), .pwmPinOe_n(oe_n));
   // Counts and reports one comparison.
   task automatic report(string n, logic [9:0] e, logic [9:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmpErr(logic [1:0] e, logic [1:0] g); report("errorType", 10'(e), 10'(g)); endtask
   task automatic cmpRun(logic e, logic g); report("runRequest", 10'(e), 10'(g)); endtask
   task automatic cmpDuty(logic [9:0] e, logic [9:0] g); report("pwmDuty", e, g); endtask
   task automatic cmpOe(logic [2:0] e, logic [2:0] g); report("pwmPinOe_n", 10'(e), 10'(g)); endtask
   task automatic waitN(int n);
      repeat (n) @(negedge clock);
   endtask
   // Drives the switch, notes the run level and waits for it under a bound.
   task automatic setSw(logic v);
      runQ.push_back(!v);
      sw = v;
      for (int i = 0; i < 3 * SW && runReq !== !v; i++) @(negedge clock);
      waitN(2);
   endtask
   // Prints the verdict and ends the run.
   task automatic wrap_up();
      report("pendingNotes", 10'h000, 10'(errQ.size() + runQ.size()));
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Takes the oldest note whenever a run level or error kind appears.
   always @(posedge clock) begin
      #1;
      if (!rst && runReq !== prevRun) cmpRun(runQ.size() ? runQ.pop_front() : prevRun, runReq);
      if (!rst && err !== prevErr && err !== 2'b00) cmpErr(errQ.size() ? errQ.pop_front() : 2'b00, err);
      prevRun = runReq;
      prevErr = err;
   end
   // Cuts a hang short; the tests take about 70000 cycles, so this leaves a clear margin.
   initial begin
      waitN(80000);
      report("watchdog", 10'h000, 10'h001);
      wrap_up();
   end
   // Main sequence: start, open then closed loop, pulse width, stop, each trip kind, restart.
   initial begin
      waitN(20);
      rst = 1'b0;
      setSw(1'b0);
      cmpDuty(10'h080, duty);
      cmpOe(3'b000, oe_n);
      waitN(3 * SW);
      report("closedLoop", 10'h001, 10'(closed));
      waitN(2 * GD);
      report("dutyRise", 10'h001, 10'(duty > 10'h080));
      // The carrier runs 1..3FE..1, so one 2042-cycle period holds 2 * duty - 3 high cycles.
      @(duty);
      waitN(2);
      repeat (2042) begin
         @(negedge clock);
         if (pins == 3'b111) hiCnt++;
      end
      report("pulseWidth", 10'(2 * duty - 3), 10'(hiCnt));
      // A high sample while driving stops the motor and floats the pins.
      setSw(1'b1);
      cmpOe(3'b111, oe_n);
      report("closedLoop", 10'h000, 10'(closed));
      setSw(1'b0);
      for (int k = 0; k < 5; k++) begin
         errQ.push_back(expErr[k]);
         if (k == 4) hwTrip = 1'b1;
         else fault = 3'(k + 1);
         #1 if (k == 4) cmpOe(3'b111, oe_n);
         waitN(GD + 10);
         cmpOe(3'b111, oe_n);
         cmpDuty(10'h000, duty);
         fault = 3'h0;
         hwTrip = 1'b0;
         waitN(2 * GD);
         cmpErr(expErr[k], err);
         setSw(1'b1);
         setSw(1'b0);
         cmpErr(2'b00, err);
      end
      wrap_up();
   end
endmodule
bind ips_supervisor ips_supervisor_monitor #(.SWITCH_CYCLES(SWITCH_CYCLES)) mon (.clock(clock), .rst(rst),
   .hwOvercurrentStopInput(hwOvercurrentStopInput), .busVoltageChannel(busVoltageChannel),
   .uCurrentChannel(uCurrentChannel), .vCurrentChannel(vCurrentChannel), .wCurrentChannel(wCurrentChannel),
   .runRequest(runRequest), .closedLoop(closedLoop), .errorType(errorType), .pwmDuty(pwmDuty),
   .pwmPinOe_n(pwmPinOe_n));
